/* File: src/trigger_select_pkg.sv */
package trigger_select_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] THRESH_OFFSET = 12'h004;
  localparam logic [11:0] SWTRIG_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;

  // Bit positions of the write-only software trigger register
  localparam int SW_AI_BIT = 0;
  localparam int SW_AO_BIT = 1;

  // Reset values and writable bits
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_0FFF;
  localparam logic [31:0] THRESH_RESET = 32'h0000_A060;
  localparam logic [31:0] THRESH_WRITE_MASK = 32'h0000_FFFF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Trigger source for each process
  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'h0,
    SRC_ANALOG = 2'h1,
    SRC_DIGITAL = 2'h2,
    SRC_SYNC_BUS = 2'h3
  } trig_src_t;

  // Analog trigger conditions; codes 5 to 7 never fire
  typedef enum logic [2:0] {
    COND_BELOW_LOW = 3'h0,
    COND_ABOVE_HIGH = 3'h1,
    COND_INSIDE = 3'h2,
    COND_HIGH_HYST = 3'h3,
    COND_LOW_HYST = 3'h4
  } condition_t;

  typedef logic [3:0][7:0] channel_codes_t;

  typedef struct packed {
    logic [19:0] reserved;
    logic ao_falling;
    logic ai_falling;
    condition_t condition;
    logic [1:0] channel;
    logic analog_source_channel;
    trig_src_t ao_source;
    trig_src_t ai_source;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] reserved;
    logic [7:0] high;
    logic [7:0] low;
  } thresh_t;

  typedef struct packed {
    logic [19:0] reserved;
    logic sync_level;
    logic output_pin_level;
    logic input_pin_level;
    logic analog_level;
    logic [7:0] sample;
  } status_t;

endpackage

/* File: src/pin_synchronizer.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_synchronizer #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Three stages; the level follows only once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.level = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.level);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule
`default_nettype wire

/* File: src/analog_condition.sv */
`timescale 1ns/100ps
`default_nettype none
module analog_condition
  import trigger_select_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] sample,
  input wire logic [7:0] low,
  input wire logic [7:0] high,
  input wire condition_t condition,
  output logic level,
  output logic pulse
);

  typedef struct packed {
    logic hyst;
    logic level;
    logic pulse;
  } cond_state_t;

  cond_state_t st;
  cond_state_t next_st;
  logic below;
  logic above;

  // Offset-binary codes order like unsigned numbers
  assign below = sample < low;
  assign above = sample > high;

  always_comb begin
    next_st = st;
    case (condition)
      COND_BELOW_LOW: next_st.level = below;
      COND_ABOVE_HIGH: next_st.level = above;
      COND_INSIDE: next_st.level = !below && !above && (sample != low) && (sample != high);
      // set above high, re-arm below low
      COND_HIGH_HYST: begin
        if (above) begin
          next_st.hyst = 1'b1;
        end else if (below) begin
          next_st.hyst = 1'b0;
        end
        next_st.level = next_st.hyst;
      end
      // set below low, re-arm above high
      COND_LOW_HYST: begin
        if (below) begin
          next_st.hyst = 1'b1;
        end else if (above) begin
          next_st.hyst = 1'b0;
        end
        next_st.level = next_st.hyst;
      end
      default: begin
        next_st.hyst = 1'b0;
        next_st.level = 1'b0;
      end
    endcase
    // one pulse on the rising condition
    next_st.pulse = next_st.level && !st.level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign pulse = st.pulse;

endmodule
`default_nettype wire

/* File: src/acquisition_trigger_select.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module acquisition_trigger_select
  import trigger_select_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] external_analog_trigger_input,
  input wire channel_codes_t channel_code,
  input wire logic input_side_digital_trigger,
  input wire logic output_side_digital_trigger,
  input wire logic sync_bus_trigger_in,
  output logic acquisition_trigger,
  output logic generation_trigger,
  output logic input_trigger_export,
  output logic output_trigger_export
);

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ctrl_t ctrl;
    thresh_t thresh;
    logic sw_ai;
    logic sw_ao;
    logic [2:0] pin_prev;
    logic acq;
    logic gen;
    logic acq_export;
    logic gen_export;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  // Filtered pin levels: bit 0 input side, bit 1 output side, bit 2 sync bus
  logic [2:0] pin_level;
  logic [7:0] sample;
  logic analog_level;
  logic analog_pulse;
  logic ai_edge;
  logic ao_edge;
  logic sync_edge;
  status_t status;

  // Byte-lane merge of a write into an existing register value
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return result;
  endfunction

  function automatic logic pick(
    input trig_src_t source,
    input logic software,
    input logic analog,
    input logic digital,
    input logic sync_bus
  );
    logic result;
    case (source)
      SRC_SOFTWARE: result = software;
      SRC_ANALOG: result = analog;
      SRC_DIGITAL: result = digital;
      SRC_SYNC_BUS: result = sync_bus;
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // pins cross into the timebase through three stages
  pin_synchronizer #(
    .WIDTH(3)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({sync_bus_trigger_in, output_side_digital_trigger, input_side_digital_trigger}),
    .level(pin_level)
  );

  // external input or one of the four channel codes
  // channel codes already span the channel's own range
  assign sample = st.ctrl.analog_source_channel ? channel_code[st.ctrl.channel]
                                                : external_analog_trigger_input;

  // one comparator unit for every source and condition
  analog_condition u_analog (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(sample),
    .low(st.thresh.low),
    .high(st.thresh.high),
    .condition(st.ctrl.condition),
    .level(analog_level),
    .pulse(analog_pulse)
  );

  // edge of the chosen polarity on each digital pin
  assign ai_edge = st.ctrl.ai_falling ? (st.pin_prev[0] && !pin_level[0])
                                      : (!st.pin_prev[0] && pin_level[0]);
  assign ao_edge = st.ctrl.ao_falling ? (st.pin_prev[1] && !pin_level[1])
                                      : (!st.pin_prev[1] && pin_level[1]);
  // Sync bus trigger is taken on its rising edge
  assign sync_edge = !st.pin_prev[2] && pin_level[2];

  // Live view for software
  always_comb begin
    status = '0;
    status.sample = sample;
    status.analog_level = analog_level;
    status.input_pin_level = pin_level[0];
    status.output_pin_level = pin_level[1];
    status.sync_level = pin_level[2];
  end

  // Handshakes: one write and one read in flight at a time
  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;

  always_comb begin
    next_st = st;
    // Software commands last one cycle only
    next_st.sw_ai = 1'b0;
    next_st.sw_ao = 1'b0;

    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Commit once both halves are held, then answer
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case ({st.aw_addr[11:2], 2'b00})
        // sources, analog setup and edge polarities
        CTRL_OFFSET: begin
          next_st.ctrl = ctrl_t'(merge(st.ctrl, st.w_data, st.w_strb) & CTRL_WRITE_MASK);
        end
        THRESH_OFFSET: begin
          next_st.thresh = thresh_t'(merge(st.thresh, st.w_data, st.w_strb) & THRESH_WRITE_MASK);
        end
        SWTRIG_OFFSET: begin
          if (st.w_strb[0]) begin
            next_st.sw_ai = st.w_data[SW_AI_BIT];
            next_st.sw_ao = st.w_data[SW_AO_BIT];
          end
        end
        // Status is read only; a write is accepted and dropped
        STATUS_OFFSET: begin
          next_st.bresp = RESP_OKAY;
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read data are captured at the address handshake
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        CTRL_OFFSET: next_st.rdata = st.ctrl;
        THRESH_OFFSET: next_st.rdata = st.thresh;
        SWTRIG_OFFSET: next_st.rdata = 32'h0000_0000;
        STATUS_OFFSET: next_st.rdata = status;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Previous filtered levels feed the edge detectors
    next_st.pin_prev = pin_level;

    // input-side trigger from its own sources
    next_st.acq = pick(st.ctrl.ai_source, st.sw_ai, analog_pulse, ai_edge, sync_edge);
    // output-side trigger from its own sources
    next_st.gen = pick(st.ctrl.ao_source, st.sw_ao, analog_pulse, ao_edge, sync_edge);
    // same pulses driven to the export pins
    next_st.acq_export = next_st.acq;
    next_st.gen_export = next_st.gen;
  end

  // Synchronous reset; registers take their reset codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ctrl <= ctrl_t'(CTRL_RESET);
      st.thresh <= thresh_t'(THRESH_RESET);
    end else begin
      st <= next_st;
    end
  end

  // Bus answers straight from registers
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Trigger outputs are registered one-cycle pulses
  assign acquisition_trigger = st.acq;
  assign generation_trigger = st.gen;
  assign input_trigger_export = st.acq_export;
  assign output_trigger_export = st.gen_export;

endmodule
`default_nettype wire

/* File: bench/trigger_select_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module trigger_select_checker
  import trigger_select_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acquisition_trigger,
  input wire logic generation_trigger,
  input wire logic input_trigger_export,
  input wire logic output_trigger_export
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Exports must never lag the process triggers
  a_export_in: assert property (input_trigger_export == acquisition_trigger)
    else $error("input export differs");
  a_export_out: assert property (output_trigger_export == generation_trigger)
    else $error("output export differs");
  // A pulse wider than one cycle would start a process twice
  a_in_pulse_once: assert property (acquisition_trigger |=> !acquisition_trigger)
    else $error("input trigger too wide");
  a_out_pulse_once: assert property (generation_trigger |=> !generation_trigger)
    else $error("output trigger too wide");
  // Register bus answers and holds its answers
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  c_in: cover property (acquisition_trigger);
  c_out: cover property (generation_trigger);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind acquisition_trigger_select trigger_select_checker trigger_select_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .acquisition_trigger(acquisition_trigger), .generation_trigger(generation_trigger),
  .input_trigger_export(input_trigger_export), .output_trigger_export(output_trigger_export)
);
`default_nettype wire

/* File: bench/trigger_sources_model.sv */
`timescale 1ns/100ps
`default_nettype none
module trigger_sources_model
  import trigger_select_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] ext_code,
  output channel_codes_t chan_code,
  output logic [2:0] pins
);
  // Quiet sources: pins low, codes at zero volts
  initial begin
    ext_code = 8'h80;
    chan_code = {4{8'h80}};
    pins = 3'h0;
  end
  task automatic put_code(input logic on_chan, input logic [7:0] v);
    @(posedge aclk);
    ext_code <= on_chan ? 8'h80 : v;
    chan_code[2] <= on_chan ? v : 8'h80;
  endtask
  // pulse one pin
  // Eight cycles, far above the minimum width the inputs need
  task automatic pulse(input int idx);
    @(posedge aclk);
    pins[idx] <= 1'b1;
    repeat (8) @(posedge aclk);
    pins[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/test_acquisition_trigger_select.sv */
`timescale 1ns/100ps
`default_nettype none
module test_acquisition_trigger_select
  import trigger_select_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, data;
  logic [3:0] wstrb;
  logic [1:0] resp;
  wire logic awready, wready, bvalid, arready, rvalid, acq, gen;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0] ext_code;
  wire channel_codes_t chan_code;
  wire logic [2:0] pins;
  int n_fail, total_checks, n_ai, n_ao, cycles;
  acquisition_trigger_select acquisition_trigger_select_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_analog_trigger_input(ext_code), .channel_code(chan_code),
    .input_side_digital_trigger(pins[0]), .output_side_digital_trigger(pins[1]),
    .sync_bus_trigger_in(pins[2]), .acquisition_trigger(acq), .generation_trigger(gen),
    .input_trigger_export(), .output_trigger_export());
  trigger_sources_model trigger_sources_model_inst (
    .aclk(aclk), .ext_code(ext_code), .chan_code(chan_code), .pins(pins));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Pulse counters; a hang ends the run well past the expected length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (acq === 1'b1) n_ai <= n_ai + 1;
    if (gen === 1'b1) n_ao <= n_ao + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Each half is released on the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_regs;
    rd(CTRL_OFFSET, data, resp);
    chk(data, CTRL_RESET);
    rd(THRESH_OFFSET, data, resp);
    chk(data, THRESH_RESET);
    rd(12'h010, data, resp);
    chk({data[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(12'h010, 32'hFFFF_FFFF, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(STATUS_OFFSET, 32'hFFFF_FFFF, resp);
    chk(32'(resp), 32'(RESP_OKAY));
    rd(STATUS_OFFSET, data, resp);
    chk(32'(data[7:0]), 32'h80);
    wr(CTRL_OFFSET, 32'hFFFF_FFFF, resp);
    rd(CTRL_OFFSET, data, resp);
    chk(data, CTRL_WRITE_MASK);
    rd(SWTRIG_OFFSET, data, resp);
    chk(data, 32'h0);
  endtask
  // Kinds 0 to 2 pulse a pin, 3 to 5 write the software command
  task automatic t_event(input int kind, input logic [31:0] ctrl, input int eai, input int eao);
    int s_ai, s_ao;
    wr(CTRL_OFFSET, ctrl, resp);
    repeat (12) @(posedge aclk);
    s_ai = n_ai;
    s_ao = n_ao;
    if (kind < 3) trigger_sources_model_inst.pulse(kind);
    else wr(SWTRIG_OFFSET, 32'(kind - 2), resp);
    repeat (12) @(posedge aclk);
    chk(32'(n_ai - s_ai), 32'(eai));
    chk(32'(n_ao - s_ao), 32'(eao));
  endtask
  // Second pass is judged, so the hysteresis state is known at its start
  task automatic t_analog(input logic src, input int cond, input int e);
    logic [7:0] seq [8] = '{8'h50, 8'hB0, 8'h80, 8'h50, 8'h80, 8'h50, 8'h80, 8'hB0};
    int s_ai, s_ao;
    wr(CTRL_OFFSET, 32'h45 | 32'(src) << 4 | 32'(cond) << 7, resp);
    for (int p = 0; p < 2; p++) begin
      s_ai = n_ai;
      s_ao = n_ao;
      for (int i = 0; i < 8; i++) begin
        trigger_sources_model_inst.put_code(src, seq[i]);
        repeat (4) @(posedge aclk);
      end
    end
    chk(32'(n_ai - s_ai), 32'(e));
    chk(32'(n_ao - s_ao), 32'(e));
  endtask
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_event(3, 32'h0, 1, 0);
    t_event(4, 32'h0, 0, 1);
    t_event(0, 32'h80A, 1, 0);
    t_event(1, 32'h80A, 0, 1);
    t_event(5, 32'h80A, 0, 0);
    t_event(0, 32'h40A, 1, 0);
    t_event(1, 32'h40A, 0, 1);
    t_event(2, 32'hF, 1, 1);
    t_event(3, 32'h9, 0, 0);
    t_event(2, 32'hC, 0, 1);
    // Reset thresholds keep high above low for every condition
    for (int s = 0; s < 2; s++) begin
      t_analog(1'(s), 0, 3);
      t_analog(1'(s), 1, 2);
      t_analog(1'(s), 2, 3);
      t_analog(1'(s), 3, 2);
      t_analog(1'(s), 4, 2);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
